/* File: design/amk_defs.svh */
`ifndef AMK_DEFS_SVH
`define AMK_DEFS_SVH

// command, sub-command and phase codes
`define AMK_CMD_ALERT_MASK   8'h1B
`define AMK_SUB_COMM_LOGIC   8'h7E
`define AMK_SUB_OTHER        8'h7F
`define AMK_SUB_VENDOR       8'h80
`define AMK_PHASE_ALL        8'hFF

// writable bits of the comm/logic and vendor masks, the rest read as zero; fixed value of the other mask
`define AMK_CML_WMASK        8'hF2
`define AMK_OTHER_FIXED      8'h01
`define AMK_MFR_WMASK        8'hCE

// field positions
`define AMK_BIT_IVC          7
`define AMK_BIT_IVD          6
`define AMK_BIT_PEC          5
`define AMK_BIT_MEM          4
`define AMK_BIT_COMM         1
`define AMK_BIT_FIRST        0
`define AMK_BIT_POR          7
`define AMK_BIT_SELF         6
`define AMK_BIT_RESET        3
`define AMK_BIT_BCX          2
`define AMK_BIT_SYNC         1

// host register offsets
`define AMK_REG_CTRL         4'h0
`define AMK_REG_WDATA        4'h1
`define AMK_REG_RDATA        4'h2
`define AMK_REG_STAT         4'h3
`define AMK_REG_IMASK        4'h4

// host control register fields
`define AMK_CTRL_WRITE       0
`define AMK_CTRL_READ        1
`define AMK_CTRL_SUB_LO      8
`define AMK_CTRL_SUB_HI      15
`define AMK_CTRL_PH_LO       16
`define AMK_CTRL_PH_HI       23

// status bits of the host
`define AMK_ST_DONE          0
`define AMK_ST_ERR           1
`define AMK_ST_BUSY          2

`define AMK_ZERO8            8'h00
`define AMK_ZERO32           32'h0000_0000

`endif

/* File: design/amk_pkg.sv */
package amk_pkg;
    typedef enum logic [1:0] {
        AMK_IDLE,
        AMK_ISSUE,
        AMK_WAIT
    } amk_hstate_t;

    typedef struct packed {
        logic       loaded;
        logic [7:0] cml;
        logic [7:0] mfr;
        logic       rdValid;
        logic [7:0] rdData;
        logic       ack;
        logic       err;
        logic       alert;
    } amk_dev_t;

    typedef struct packed {
        amk_hstate_t st;
        logic        req;
        logic        wr;
        logic [7:0]  sub;
        logic [7:0]  phase;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic [2:0]  status;
        logic [2:0]  imask;
        logic [31:0] rd;
        logic        irq;
    } amk_host_t;
endpackage : amk_pkg

/* File: design/amk_link_if.sv */
`timescale 1ns/1ps
interface amk_link_if;
    logic       req;
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] sub;
    logic [7:0] phase;
    logic [7:0] wdata;
    logic       ack;
    logic       err;
    logic [7:0] rdata;

    modport dev  (input req, wr, cmd, sub, phase, wdata,
                  output ack, err, rdata);
    modport host (output req, wr, cmd, sub, phase, wdata,
                  input ack, err, rdata);
endinterface : amk_link_if

/* File: design/amk_host.sv */
`timescale 1ns/1ps
`include "amk_defs.svh"
module amk_host (
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    amk_link_if.host   link,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    output logic             irq
);
    amk_pkg::amk_host_t s_q;
    amk_pkg::amk_host_t s_d;

    assign link.req   = s_q.req;
    assign link.wr    = s_q.wr;
    assign link.cmd   = `AMK_CMD_ALERT_MASK;
    assign link.sub   = s_q.sub;
    assign link.phase = s_q.phase;
    assign link.wdata = s_q.wdata;
    assign regRdata   = s_q.rd;
    assign irq        = s_q.irq;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d     = s_q;
        s_d.req = 1'b0;
        s_d.rd  = `AMK_ZERO32;
        if (regWr) begin
            if (regAddr == `AMK_REG_CTRL) begin
                if (s_q.st == amk_pkg::AMK_IDLE &&
                    (regWdata[`AMK_CTRL_WRITE] ||
                     regWdata[`AMK_CTRL_READ])) begin
                    s_d.wr    = regWdata[`AMK_CTRL_WRITE];
                    s_d.sub   = regWdata[`AMK_CTRL_SUB_HI:`AMK_CTRL_SUB_LO];
                    s_d.phase = regWdata[`AMK_CTRL_PH_HI:`AMK_CTRL_PH_LO];
                    s_d.st    = amk_pkg::AMK_ISSUE;
                end
            end else if (regAddr == `AMK_REG_WDATA) begin
                s_d.wdata = regWdata[7:0];
            end else if (regAddr == `AMK_REG_STAT) begin
                s_d.status = s_q.status & ~regWdata[2:0];
            end else if (regAddr == `AMK_REG_IMASK) begin
                s_d.imask = regWdata[2:0];
            end
        end
        if (regRd) begin
            if (regAddr == `AMK_REG_CTRL) begin
                s_d.rd = {8'h00, s_q.phase, s_q.sub, 7'h00, s_q.wr};
            end else if (regAddr == `AMK_REG_WDATA) begin
                s_d.rd = {24'h00_0000, s_q.wdata};
            end else if (regAddr == `AMK_REG_RDATA) begin
                s_d.rd = {24'h00_0000, s_q.rdata};
            end else if (regAddr == `AMK_REG_STAT) begin
                s_d.rd = {29'h0000_0000, s_q.st != amk_pkg::AMK_IDLE,
                          s_q.status[1:0]};
            end else if (regAddr == `AMK_REG_IMASK) begin
                s_d.rd = {29'h0000_0000, s_q.imask};
            end
        end
        case (s_q.st)
            amk_pkg::AMK_IDLE: begin
            end
            amk_pkg::AMK_ISSUE: begin
                // sub-command selects the mask group
                s_d.req = 1'b1;
                s_d.st  = amk_pkg::AMK_WAIT;
            end
            amk_pkg::AMK_WAIT: begin
                if (link.ack) begin
                    if (!s_q.wr) begin
                        s_d.rdata = link.rdata;
                    end
                    // set wins over a simultaneous clear
                    s_d.status[`AMK_ST_DONE] = 1'b1;
                    if (link.err) begin
                        s_d.status[`AMK_ST_ERR] = 1'b1;
                    end
                    s_d.st = amk_pkg::AMK_IDLE;
                end
            end
            default: s_d.st = amk_pkg::AMK_IDLE;
        endcase
        s_d.irq = |(s_d.status[1:0] & s_d.imask[1:0]);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{st: amk_pkg::AMK_IDLE, phase: `AMK_PHASE_ALL,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end
endmodule : amk_host

/* File: design/amk_dev.sv */
`timescale 1ns/1ps
`include "amk_defs.svh"
// Contract
// - sub-command 7Eh selects comm/logic mask
// - sub-command 7Fh selects other mask
// - sub-command 80h selects vendor mask
// - mask bit zero lets alert through (other-mask status never alerts here)
// - mask bit one blocks the alert
// - comm/logic bits 7:4 writable, 3:2 zero
// - comm/logic bit 1 writable, bit 0 zero
// - comm/logic mask accepts only phase FFh
// - first-alerter flag never raises alert
// - other mask reads fixed 01h
// - vendor bits 7:6 writable, 5:4 zero
// - vendor bits 3:1 writable, bit 0 zero
// - self-check mask cleared may alert early
// - sync mask cleared may alert briefly
module amk_dev (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    amk_link_if.dev         link,
    input  wire logic [7:0] nvmCml,
    input  wire logic [7:0] nvmMfr,
    input  wire logic [7:0] cmlStatus,
    input  wire logic [7:0] otherStatus,
    input  wire logic [7:0] vendorStatusByte,
    output logic      [7:0] maskCml,
    output logic      [7:0] maskMfr,
    output logic            alertOut
);
    amk_pkg::amk_dev_t s_q;
    amk_pkg::amk_dev_t s_d;

    // only the writable bits survive, so read-only bits stay zero
    function automatic logic [7:0] keepCml(input logic [7:0] v);
        return v & `AMK_CML_WMASK;
    endfunction : keepCml

    function automatic logic [7:0] keepMfr(input logic [7:0] v);
        return v & `AMK_MFR_WMASK;
    endfunction : keepMfr

    assign link.ack   = s_q.ack;
    assign link.err   = s_q.err;
    assign link.rdata = s_q.rdData;
    assign maskCml    = s_q.cml;
    assign maskMfr    = s_q.mfr;
    assign alertOut   = s_q.alert;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d        = s_q;
        s_d.ack    = 1'b0;
        s_d.err    = 1'b0;
        s_d.loaded = 1'b1;
        // storage image loads once after reset release
        if (!s_q.loaded) begin
            s_d.cml = keepCml(nvmCml);
            s_d.mfr = keepMfr(nvmMfr);
        end else if (link.req) begin
            s_d.ack = 1'b1;
            if (link.cmd != `AMK_CMD_ALERT_MASK) begin
                s_d.err = 1'b1;
            end else if (link.sub == `AMK_SUB_COMM_LOGIC) begin
                if (link.phase != `AMK_PHASE_ALL) begin
                    s_d.err = 1'b1;
                end else begin
                    if (link.wr) begin
                        // read-only bits stay zero
                        s_d.cml = keepCml(link.wdata);
                    end
                    s_d.rdData = s_q.cml;
                end
            end else if (link.sub == `AMK_SUB_OTHER) begin
                // writes land nowhere: the whole byte is fixed
                s_d.rdData = `AMK_OTHER_FIXED;
            end else if (link.sub == `AMK_SUB_VENDOR) begin
                if (link.wr) begin
                    s_d.mfr = keepMfr(link.wdata);
                end
                s_d.rdData = s_q.mfr;
            end else begin
                s_d.err = 1'b1;
            end
            if (s_d.err || link.wr) begin
                s_d.rdData = `AMK_ZERO8;
            end
        end
        // new masks gate the alert from the same edge that stores them
        // a clear writable mask bit passes its status, a set one blocks it
        // the self-check and sync sources are not
        // filtered, so unmasking them may alert at start-up
        // the first-alerter flag is always masked
        s_d.alert = |(cmlStatus & `AMK_CML_WMASK & ~s_d.cml)
                  | |(otherStatus & ~`AMK_OTHER_FIXED & `AMK_ZERO8)
                  | |(vendorStatusByte & `AMK_MFR_WMASK & ~s_d.mfr);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : amk_dev

/* File: sim/amk_link_assertions.sv */
`timescale 1ns/1ps
module amk_link_assertions (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       req,
    input wire logic       wr,
    input wire logic [7:0] cmd,
    input wire logic [7:0] sub,
    input wire logic [7:0] phase,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic       err,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
////////////////////////////////////////
    property p_ack; req |=> ack; endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    property p_lone; ack |-> $past(req); endproperty
    a_lone: assert property (p_lone) else $error("stray ack");
    property p_cmd; req |-> cmd == 8'h1B; endproperty
    a_cmd: assert property (p_cmd) else $error("bad command");
    property p_phase;
        req && sub == 8'h7E && phase != 8'hFF |=> err;
    endproperty
    a_phase: assert property (p_phase) else $error("phase not refused");
    property p_errack; err |-> ack; endproperty
    a_errack: assert property (p_errack) else $error("err without ack");
    property p_cml; req && !wr && sub == 8'h7E |=> (rdata & 8'h0D) == 8'h00;
    endproperty
    a_cml: assert property (p_cml) else $error("comm bits set");
    property p_other; req && !wr && sub == 8'h7F |=> !err && rdata == 8'h01;
    endproperty
    a_other: assert property (p_other) else $error("other mask");
    property p_mfr; req && !wr && sub == 8'h80 |=> (rdata & 8'h31) == 8'h00;
    endproperty
    a_mfr: assert property (p_mfr) else $error("vendor bits set");
    c_write: cover property (req && wr);
    c_refuse: cover property (err);
    c_vendor: cover property (req && !wr && sub == 8'h80);
endmodule : amk_link_assertions

/* File: sim/test_alert_mask_cml_other_mfr.sv */
`timescale 1ns/1ps
`include "amk_defs.svh"
module test_alert_mask_cml_other_mfr;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0000_0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdata;
    logic        irq;
    logic [7:0]  nvmCml = 8'hFF;
    logic [7:0]  nvmMfr = 8'hFF;
    logic [7:0]  cmlStatus = 8'h00;
    logic [7:0]  otherStatus = 8'h00;
    logic [7:0]  vendorStatusByte = 8'h00;
    logic [7:0]  maskCml, maskMfr, rb;
    logic        alertOut, re;
    logic [31:0] rv;
    int          errors = 0;
    int          n_checks = 0;
    amk_link_if amk_link_if_inst ();
    amk_host amk_host_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .link(amk_link_if_inst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
    amk_dev amk_dev_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .link(amk_link_if_inst), .nvmCml(nvmCml), .nvmMfr(nvmMfr),
        .cmlStatus(cmlStatus), .otherStatus(otherStatus),
        .vendorStatusByte(vendorStatusByte), .maskCml(maskCml),
        .maskMfr(maskMfr), .alertOut(alertOut));
    amk_link_assertions amk_link_assertions_inst (.clk_sys(clk_sys),
        .rst_n(rst_n), .req(amk_link_if_inst.req), .wr(amk_link_if_inst.wr),
        .cmd(amk_link_if_inst.cmd), .sub(amk_link_if_inst.sub),
        .phase(amk_link_if_inst.phase), .wdata(amk_link_if_inst.wdata),
        .ack(amk_link_if_inst.ack), .err(amk_link_if_inst.err),
        .rdata(amk_link_if_inst.rdata));
    always #10 clk_sys = ~clk_sys;
////////////////////////////////////////
    task chk(input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task regW(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : regW
    // read data stands only in the cycle after the strobe
    task regR(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : regR
    task waitDone;
        int i;
        rv = 32'h0000_0000;
        for (i = 0; i < 20 && rv[0] !== 1'b1; i++) regR(`AMK_REG_STAT, rv);
        if (rv[0] !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: no completion", $time);
            conclude();
        end
    endtask : waitDone
    // one link access; done and err cleared afterwards so the next starts clean
    task acc(input logic [7:0] s, p, input logic w, input logic [7:0] d, x,
             input logic xe);
        regW(`AMK_REG_WDATA, {24'h00_0000, d});
        regW(`AMK_REG_CTRL, {8'h00, p, s, 6'h00, ~w, w});
        waitDone();
        re = rv[1];
        regR(`AMK_REG_RDATA, rv);
        if (!w) chk(rv[7:0], x);
        chk({7'h00, re}, {7'h00, xe});
        regW(`AMK_REG_STAT, 32'h0000_0003);
    endtask : acc
    task t_load;
        #1 chk(maskCml, 8'hF2);
        chk(maskMfr, 8'hCE);
        acc(8'h7E, 8'hFF, 1'b0, 8'h00, 8'hF2, 1'b0);
        acc(8'h7F, 8'hFF, 1'b0, 8'h00, 8'h01, 1'b0);
        acc(8'h80, 8'hFF, 1'b0, 8'h00, 8'hCE, 1'b0);
        $display("load test done");
    endtask : t_load
    task t_write;
        acc(8'h7E, 8'hFF, 1'b1, 8'h0D, 8'h00, 1'b0);
        acc(8'h7E, 8'hFF, 1'b0, 8'h00, 8'h00, 1'b0);
        acc(8'h80, 8'hFF, 1'b1, 8'h31, 8'h00, 1'b0);
        acc(8'h80, 8'hFF, 1'b0, 8'h00, 8'h00, 1'b0);
        acc(8'h80, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0);
        acc(8'h7B, 8'hFF, 1'b0, 8'h00, 8'h00, 1'b1);
        acc(8'h7F, 8'hFF, 1'b1, 8'h00, 8'h00, 1'b0);
        acc(8'h7F, 8'hFF, 1'b0, 8'h00, 8'h01, 1'b0);
        acc(8'h7E, 8'h00, 1'b1, 8'hF2, 8'h00, 1'b1);
        #1 chk(maskCml, 8'h00);
        $display("write test done");
    endtask : t_write
    task t_alert;
        logic [15:0] sup;
        int i;
        sup = 16'hCEF2;
        for (i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            {vendorStatusByte, cmlStatus} <= 16'h0001 << i;
            repeat (2) @(posedge clk_sys);
            #1 chk({7'h00, alertOut}, {7'h00, sup[i]});
        end
        @(posedge clk_sys);
        {vendorStatusByte, cmlStatus} <= 16'h0000;
        otherStatus <= 8'h01;
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h00, alertOut}, 8'h00);
        acc(8'h7E, 8'hFF, 1'b1, 8'hFF, 8'h00, 1'b0);
        acc(8'h80, 8'hFF, 1'b1, 8'hFF, 8'h00, 1'b0);
        acc(8'h80, 8'hFF, 1'b0, 8'h00, 8'hCE, 1'b0);
        @(posedge clk_sys);
        {vendorStatusByte, cmlStatus} <= 16'hFFFF;
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h00, alertOut}, 8'h00);
        acc(8'h80, 8'hFF, 1'b1, 8'h00, 8'h00, 1'b0);
        #1 chk({7'h00, alertOut}, 8'h01);
        $display("alert test done");
    endtask : t_alert
    task t_irq;
        regW(`AMK_REG_IMASK, 32'h0000_0000);
        regW(`AMK_REG_CTRL, 32'h00FF_7F02);
        regR(`AMK_REG_STAT, rv);
        chk({7'h00, rv[2]}, 8'h01);
        waitDone();
        chk({7'h00, irq}, 8'h00);
        regW(`AMK_REG_IMASK, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        #1 chk({7'h00, irq}, 8'h01);
        regW(`AMK_REG_STAT, 32'h0000_0003);
        repeat (3) @(posedge clk_sys);
        #1 chk({7'h00, irq}, 8'h00);
        regW(`AMK_REG_IMASK, 32'h0000_0002);
        regW(`AMK_REG_CTRL, 32'h0000_7E02);
        waitDone();
        chk({7'h00, irq}, 8'h01);
        regW(`AMK_REG_STAT, 32'h0000_0003);
        regR(4'hF, rv);
        chk({7'h00, |rv}, 8'h00);
        $display("irq test done");
    endtask : t_irq
    // a second reset must reload the masks from a new storage image
    task t_reset;
        @(posedge clk_sys);
        nvmCml <= 8'h5A;
        nvmMfr <= 8'hA5;
        rst_n  <= 1'b0;
        #1 chk(maskCml, 8'h00);
        chk({7'h00, alertOut}, 8'h00);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 chk(maskCml, 8'h52);
        chk(maskMfr, 8'h84);
        chk({7'h00, alertOut}, 8'h01);
        acc(8'h80, 8'hFF, 1'b0, 8'h00, 8'h84, 1'b0);
        $display("reset test done");
    endtask : t_reset
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        // masks load at the first edge, requests count from the second
        repeat (4) @(posedge clk_sys);
        t_load();
        t_write();
        t_alert();
        t_irq();
        t_reset();
        conclude();
    end
endmodule : test_alert_mask_cml_other_mfr
